// *** fbm_status_pkg.sv ***
/*
 Shared constants and types for the fieldbus master status logic:
 display codes, system log codes, register offsets, reset values and
 the hold time of one display item.
 Assumes a single 50 MHz module clock.
*/
package fbm_status_pkg;

   // Module clock and display hold time
   localparam int CLK_HZ = 50_000_000;
   localparam int HOLD_TIME_MS = 500;
   localparam int HOLD_CYCLES = HOLD_TIME_MS * (CLK_HZ / 1000);

   // Node address range of slaves and of the master
   localparam int SLAVE_COUNT = 128;
   localparam logic [6:0] NODE_ADDR_MAX = 7'h7d;

   // Display codes
   localparam logic [7:0] DISP_STOP = 8'h80;
   localparam logic [7:0] DISP_OFFLINE = 8'he2;
   localparam logic [7:0] DISP_REMOTE = 8'he6;
   localparam logic [7:0] DISP_CFG_EMPTY = 8'hf1;
   localparam logic [7:0] DISP_NO_IOMAP = 8'hf2;
   localparam logic [7:0] DISP_TEST_MODE = 8'hf3;
   localparam logic [7:0] DISP_INIT_FAIL = 8'hf4;
   localparam logic [7:0] DISP_CHIP_TMO = 8'hf5;
   localparam logic [7:0] DISP_STORE_ERR = 8'hf6;
   localparam logic [7:0] DISP_XCHG_ERR = 8'hf7;
   localparam logic [7:0] DISP_SERIAL_ERR = 8'hf8;
   localparam logic [7:0] DISP_PLC_TMO = 8'hfb;

   // System log codes
   localparam logic [15:0] LOG_NONE = 16'h0000;
   localparam logic [15:0] LOG_OFFLINE = 16'ha4e2;
   localparam logic [15:0] LOG_REMOTE = 16'ha4e6;
   localparam logic [15:0] LOG_CFG_EMPTY = 16'ha001;
   localparam logic [15:0] LOG_NO_IOMAP = 16'ha402;
   localparam logic [15:0] LOG_TEST_MODE = 16'ha003;
   localparam logic [15:0] LOG_INIT_FAIL = 16'ha404;
   localparam logic [15:0] LOG_CHIP_TMO = 16'ha405;
   localparam logic [15:0] LOG_STORE_ERR = 16'ha406;
   localparam logic [15:0] LOG_XCHG_ERR = 16'ha407;
   localparam logic [15:0] LOG_SERIAL_ERR = 16'ha408;
   localparam logic [15:0] LOG_PLC_TMO = 16'ha00b;

   // Network state values
   localparam logic [15:0] NET_NOT_FOUND = 16'h0000;
   localparam logic [15:0] NET_OFFLINE = 16'h0001;
   localparam logic [15:0] NET_STOPPED = 16'h0002;
   localparam logic [15:0] NET_IDLE = 16'h0003;
   localparam logic [15:0] NET_RUN = 16'h0004;

   // Register offsets (word index on the register port)
   localparam logic [2:0] REG_NET_STATE = 3'h0;
   localparam logic [2:0] REG_OFFLINE_CNT = 3'h1;
   localparam logic [2:0] REG_FAULT_CODE = 3'h2;
   localparam logic [2:0] REG_COMM_HIGH = 3'h3;
   localparam logic [2:0] REG_COMM_CTRL = 3'h4;

   // Control register field and reset value
   localparam int CTRL_COMM_ENABLE_BIT = 0;
   localparam logic COMM_ENABLE_RESET = 1'b1;

   // Fault vector positions, highest priority first
   localparam int FLT_XCHG = 0;
   localparam int FLT_STORE = 1;
   localparam int FLT_TEST = 2;
   localparam int FLT_INIT = 3;
   localparam int FLT_SERIAL = 4;
   localparam int FLT_CHIP = 5;
   localparam int FLT_CFG = 6;
   localparam int FLT_REMOTE = 7;
   localparam int FLT_COUNT = 8;

   // Display phase, Gray coded along the item sequence
   typedef enum logic [1:0] {
      PH_0 = 2'b00,
      PH_1 = 2'b01,
      PH_2 = 2'b11,
      PH_3 = 2'b10
   } phase_t;

   // Display mode
   typedef enum logic [2:0] {
      MD_ADDR = 3'h0,
      MD_STOP = 3'h1,
      MD_OFF = 3'h2,
      MD_OFF_STOP = 3'h3,
      MD_CODE = 3'h4
   } mode_t;

endpackage : fbm_status_pkg

// *** offline_if.sv ***
/*
 Signals between the status logic and the offline slave table.
 Assumes both ends run on the same module clock.
*/
`timescale 1ns/1ps
interface offline_if;
   logic down;
   logic up;
   logic [6:0] ev_addr;
   logic [6:0] start;
   logic [6:0] next_addr;
   logic any;
   logic newly_down;

   modport table_end (input down, up, ev_addr, start, output next_addr, any, newly_down);
   modport user_end (output down, up, ev_addr, start, input next_addr, any, newly_down);
endinterface : offline_if

// *** offline_table.sv ***
/*
 Offline slave table: one flag per node address, set by offline
 events and cleared by online events, with an ascending search.
 Assumes events come from logic on the same clock.
*/
`timescale 1ns/1ps
module offline_table
   import fbm_status_pkg::*;
#(
   parameter int SLAVES = SLAVE_COUNT
) (
   input wire logic mclk,
   input wire logic reset,
   offline_if.table_end ol
);

   logic slave_down [0:SLAVES-1];
   logic found;
   logic any_down;
   logic [6:0] hit;
   logic [6:0] idx;

   // Event only counts when the slave was not already offline
   wire valid_addr = ol.ev_addr <= NODE_ADDR_MAX;
   assign ol.newly_down = ol.down && valid_addr && !slave_down[ol.ev_addr];

   // Down wins when both events name one slave in one cycle
   always_ff @(posedge mclk) begin
      for (int i = 0; i < SLAVES; i++) begin
         if (reset) begin
            slave_down[i] <= 1'b0;
         end else if (ol.down && valid_addr && ol.ev_addr == 7'(i)) begin
            slave_down[i] <= 1'b1;
         end else if (ol.up && ol.ev_addr == 7'(i)) begin
            slave_down[i] <= 1'b0;
         end
      end
   end

   // First offline slave at or above start, wrapping round
   always_comb begin
      found = 1'b0;
      hit = ol.start;
      idx = 7'h00;
      for (int i = 0; i < SLAVES; i++) begin
         idx = ol.start + 7'(i);
         if (!found && slave_down[idx]) begin
            found = 1'b1;
            hit = idx;
         end
      end
   end

   // Any slave offline; kept apart from the search so the mode pick never loops through start
   always_comb begin
      any_down = 1'b0;
      for (int i = 0; i < SLAVES; i++) begin
         any_down = any_down | slave_down[i];
      end
   end

   assign ol.next_addr = hit;
   assign ol.any = any_down;

endmodule : offline_table

// *** fbm_status.sv ***
/*
 Diagnostic status logic of the fieldbus master: picks the code for the
 two-digit display and its rotating order, and serves the status words.
 Assumes fault and run levels arrive as pins (synchronised here), slave
 events arrive from the protocol engine on mclk, and software uses the
 plain register port with read data one cycle after the read strobe.
*/
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module fbm_status
   import fbm_status_pkg::*;
#(
   parameter int HOLD = HOLD_CYCLES
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [6:0] node_addr,
   input wire logic cpu_run,
   input wire logic master_found,
   input wire logic xchg_fault,
   input wire logic store_fault,
   input wire logic test_mode,
   input wire logic init_fail,
   input wire logic serial_fail,
   input wire logic chip_timeout,
   input wire logic cfg_empty,
   input wire logic remote_fault,
   input wire logic no_io_map,
   input wire logic plc_timeout,
   input wire logic slave_down,
   input wire logic slave_up,
   input wire logic [6:0] slave_addr,
   input wire logic [2:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic [7:0] disp_code
);

   // Seven address bits and twelve single-bit levels
   localparam int PIN_W = 19;

   // Link to the offline slave table
   offline_if ol();

   // Pin synchroniser stages
   logic [PIN_W-1:0] pin_meta;
   logic [PIN_W-1:0] pin_sync;

   // Status word and display sequencer state
   logic comm_enable;
   logic [15:0] offline_count;
   logic [31:0] hold_count;
   logic [6:0] cur_slave;
   phase_t phase;
   mode_t mode;
   phase_t next_phase;

   // Priority pick of the fault code, highest first
   function automatic logic [7:0] pick_disp(input logic [FLT_COUNT-1:0] f);
      logic [7:0] code;
      code = 8'h00;
      if (f[FLT_XCHG]) begin
         code = DISP_XCHG_ERR;
      end else if (f[FLT_STORE]) begin
         code = DISP_STORE_ERR;
      end else if (f[FLT_TEST]) begin
         code = DISP_TEST_MODE;
      end else if (f[FLT_INIT]) begin
         code = DISP_INIT_FAIL;
      end else if (f[FLT_SERIAL]) begin
         code = DISP_SERIAL_ERR;
      end else if (f[FLT_CHIP]) begin
         code = DISP_CHIP_TMO;
      end else if (f[FLT_CFG]) begin
         code = DISP_CFG_EMPTY;
      end else if (f[FLT_REMOTE]) begin
         code = DISP_REMOTE;
      end
      return code;
   endfunction : pick_disp

   // Log code for a display code, one table for every fault code
   function automatic logic [15:0] log_of(input logic [7:0] code);
      logic [15:0] lc;
      case (code)
         DISP_XCHG_ERR: lc = LOG_XCHG_ERR;
         DISP_STORE_ERR: lc = LOG_STORE_ERR;
         DISP_TEST_MODE: lc = LOG_TEST_MODE;
         DISP_INIT_FAIL: lc = LOG_INIT_FAIL;
         DISP_SERIAL_ERR: lc = LOG_SERIAL_ERR;
         DISP_CHIP_TMO: lc = LOG_CHIP_TMO;
         DISP_CFG_EMPTY: lc = LOG_CFG_EMPTY;
         DISP_REMOTE: lc = LOG_REMOTE;
         DISP_OFFLINE: lc = LOG_OFFLINE;
         DISP_NO_IOMAP: lc = LOG_NO_IOMAP;
         DISP_PLC_TMO: lc = LOG_PLC_TMO;
         default: lc = LOG_NONE;
      endcase
      return lc;
   endfunction : log_of

   // Two flip-flops on every pin level before any logic sees it
   wire [PIN_W-1:0] pin_raw = {
      node_addr,
      cpu_run,
      master_found,
      xchg_fault,
      store_fault,
      test_mode,
      init_fail,
      serial_fail,
      chip_timeout,
      cfg_empty,
      remote_fault,
      no_io_map,
      plc_timeout
   };

   // Reset clears both stages, so for two edges the CPU looks stopped
   always_ff @(posedge mclk) begin
      if (reset) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end

   // Synchronised levels by name, in pin_raw order
   wire [6:0] own_addr = pin_sync[18:12];
   wire run_s = pin_sync[11];
   wire found_s = pin_sync[10];
   wire xchg_s = pin_sync[9];
   wire store_s = pin_sync[8];
   wire test_s = pin_sync[7];
   wire init_s = pin_sync[6];
   wire serial_s = pin_sync[5];
   wire chip_s = pin_sync[4];
   wire cfg_s = pin_sync[3];
   wire remote_s = pin_sync[2];
   wire iomap_s = pin_sync[1];
   wire plctmo_s = pin_sync[0];

   // Fault vector by priority position; bit order must match pick_disp
   wire [FLT_COUNT-1:0] faults;
   assign faults[FLT_XCHG] = xchg_s;
   assign faults[FLT_STORE] = store_s;
   assign faults[FLT_TEST] = test_s;
   assign faults[FLT_INIT] = init_s;
   assign faults[FLT_SERIAL] = serial_s;
   assign faults[FLT_CHIP] = chip_s;
   assign faults[FLT_CFG] = cfg_s;
   assign faults[FLT_REMOTE] = remote_s;

   // Upper faults outrank the shared offline and stop level
   wire [7:0] top_code = pick_disp(faults);
   wire top_fault = |faults;
   wire any_off = ol.any;
   wire stopped = !run_s;

   // Below E2 and 80 come F2, then FB
   wire [7:0] low_code = iomap_s ? DISP_NO_IOMAP : DISP_PLC_TMO;
   wire low_fault = iomap_s || plctmo_s;

   // Mode choice; E2 and 80 together rotate as one level
   wire mode_t next_mode =
      top_fault ? MD_CODE :
      (any_off && stopped) ? MD_OFF_STOP :
      any_off ? MD_OFF :
      stopped ? MD_STOP :
      low_fault ? MD_CODE :
      MD_ADDR;
   wire [7:0] fault_code = top_fault ? top_code : low_code;

   // Own address clamped to the legal node range
   wire [7:0] addr_code = (own_addr > NODE_ADDR_MAX) ? {1'b0, NODE_ADDR_MAX} : {1'b0, own_addr};

   // Items per mode, in display order
   wire [1:0] last_step =
      (mode == MD_OFF_STOP) ? 2'h3 :
      (mode == MD_OFF || mode == MD_STOP) ? 2'h1 : 2'h0;

   // Phase position as a plain step number
   wire [1:0] step =
      (phase == PH_0) ? 2'h0 :
      (phase == PH_1) ? 2'h1 :
      (phase == PH_2) ? 2'h2 : 2'h3;

   // Item shown for each mode and step
   wire [7:0] item_off_stop =
      (step == 2'h0) ? DISP_STOP :
      (step == 2'h1) ? addr_code :
      (step == 2'h2) ? DISP_OFFLINE : {1'b0, cur_slave};
   wire [7:0] item_off = (step == 2'h0) ? DISP_OFFLINE : {1'b0, cur_slave};
   wire [7:0] item_stop = (step == 2'h0) ? addr_code : DISP_STOP;
   wire [7:0] item =
      (mode == MD_OFF_STOP) ? item_off_stop :
      (mode == MD_OFF) ? item_off :
      (mode == MD_STOP) ? item_stop :
      (mode == MD_CODE) ? fault_code : addr_code;

   // Hold expiry; a mode change restarts the count from zero
   wire hold_done = hold_count >= 32'(HOLD - 1);
   wire mode_change = next_mode != mode;

   // End of a pass; only the offline modes move on to another slave
   wire wrap = step == last_step;
   wire slave_step = hold_done && wrap && (mode == MD_OFF || mode == MD_OFF_STOP);

   // Next phase along the Gray path
   always_comb begin
      case (phase)
         PH_0: next_phase = PH_1;
         PH_1: next_phase = PH_2;
         PH_2: next_phase = PH_3;
         PH_3: next_phase = PH_0;
         default: next_phase = PH_0;
      endcase
      if (wrap) begin
         next_phase = PH_0;
      end
   end

   // Search starts at zero on entry, else past the shown slave
   assign ol.start = mode_change ? 7'h00 : cur_slave + 7'h01;
   assign ol.down = slave_down;
   assign ol.up = slave_up;
   assign ol.ev_addr = slave_addr;

   // Offline slave table, one flag per node address
   offline_table #(
      .SLAVES(SLAVE_COUNT)
   ) i_offline_table (
      .mclk(mclk),
      .reset(reset),
      .ol(ol)
   );

   // Mode, phase and hold timer; a new mode restarts its sequence
   always_ff @(posedge mclk) begin
      if (reset) begin
         mode <= MD_ADDR;
         phase <= PH_0;
         hold_count <= 32'h0;
      end else if (mode_change) begin
         mode <= next_mode;
         phase <= PH_0;
         hold_count <= 32'h0;
      end else if (hold_done) begin
         phase <= next_phase;
         hold_count <= 32'h0;
      end else begin
         hold_count <= hold_count + 32'h1;
      end
   end

   // Slave shown; moves on once per pass of the sequence
   always_ff @(posedge mclk) begin
      if (reset) begin
         cur_slave <= 7'h00;
      end else if (mode_change || slave_step) begin
         cur_slave <= ol.next_addr;
      end
   end

   // Display register, refreshed every cycle
   always_ff @(posedge mclk) begin
      if (reset) begin
         disp_code <= 8'h00;
      end else begin
         disp_code <= item;
      end
   end

   // Offline events since reset; no write path clears it
   always_ff @(posedge mclk) begin
      if (reset) begin
         offline_count <= 16'h0000;
      end else if (ol.newly_down) begin
         offline_count <= offline_count + 16'h0001;
      end
   end

   // Network state, worst condition first
   wire [15:0] net_state =
      !found_s ? NET_NOT_FOUND :
      cfg_s ? NET_OFFLINE :
      !comm_enable ? NET_STOPPED :
      stopped ? NET_IDLE : NET_RUN;

   // Fault word follows the fault code; the offline modes give E2 for the whole rotation, stop alone gives none
   wire [7:0] log_disp =
      (mode == MD_OFF || mode == MD_OFF_STOP) ? DISP_OFFLINE :
      (mode == MD_CODE) ? fault_code : 8'h00;
   wire [15:0] fault_word = log_of(log_disp);

   // Communication enable; the only writable bit
   always_ff @(posedge mclk) begin
      if (reset) begin
         comm_enable <= COMM_ENABLE_RESET;
      end else if (reg_wr && reg_addr == REG_COMM_CTRL) begin
         comm_enable <= reg_wdata[CTRL_COMM_ENABLE_BIT];
      end
   end

   // Read decode; unmapped and reserved words read as zero
   wire [15:0] rd_value =
      (reg_addr == REG_NET_STATE) ? net_state :
      (reg_addr == REG_OFFLINE_CNT) ? offline_count :
      (reg_addr == REG_FAULT_CODE) ? fault_word :
      (reg_addr == REG_COMM_HIGH) ? 16'h0000 :
      (reg_addr == REG_COMM_CTRL) ? {15'h0000, comm_enable} : 16'h0000;

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (reset) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= reg_rd ? rd_value : 16'h0000;
      end
   end

endmodule : fbm_status

// *** slave_bus_model.sv ***
/*
 Behavioural model of the slave side: offline and online events.
 Assumes events are taken on the rising edge of mclk.
*/
`timescale 1ns/1ps
module slave_bus_model (
   input wire logic mclk,
   output logic slave_down,
   output logic slave_up,
   output logic [6:0] slave_addr
);
   // Quiet lines at time zero
   initial begin
      slave_down = 1'b0;
      slave_up = 1'b0;
      slave_addr = 7'h00;
   end

   // One-cycle event; the address is inverted afterwards so a stale value never passes
   task send(input logic dn, input logic [6:0] a);
      @(posedge mclk);
      slave_down <= dn;
      slave_up <= !dn;
      slave_addr <= a;
      @(posedge mclk);
      slave_down <= 1'b0;
      slave_up <= 1'b0;
      slave_addr <= ~a;
   endtask : send
endmodule : slave_bus_model

// *** fbm_status_assertions.sv ***
/*
 Port checker for fbm_status: register answers and display priority.
 Assumes pins reach the display within four edges.
*/
`timescale 1ns/1ps
module fbm_status_checker
   import fbm_status_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic master_found,
   input wire logic xchg_fault,
   input wire logic store_fault,
   input wire logic slave_down,
   input wire logic [2:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [7:0] disp_code
);
   // One domain, so clock and reset are given once
   default clocking @(posedge mclk);
   endclocking
   default disable iff (reset);

   // Register answers, one cycle after the strobe
   chk_reserved_zero: assert property (reg_rd && reg_addr == REG_COMM_HIGH
      |=> reg_rdata == 16'h0000) else $error("reserved word not zero");
   chk_count_kept: assert property ((reg_rd && reg_addr == REG_OFFLINE_CNT && !slave_down)
      ##1 (reg_rd && reg_addr == REG_OFFLINE_CNT) |=> reg_rdata == $past(reg_rdata))
      else $error("offline count moved without an event");
   chk_net_range: assert property (reg_rd && reg_addr == REG_NET_STATE
      |=> reg_rdata <= NET_RUN) else $error("network state out of range");
   chk_not_found: assert property ((!master_found [*6] ##0 (reg_rd && reg_addr == REG_NET_STATE))
      |=> reg_rdata == NET_NOT_FOUND) else $error("missing master not reported");
   chk_comm_off: assert property ((reg_wr && reg_addr == REG_COMM_CTRL && !reg_wdata[0])
      ##1 (reg_rd && reg_addr == REG_NET_STATE) |=> reg_rdata <= NET_STOPPED)
      else $error("disabled link still reports idle or run");
   chk_fault_word: assert property ((xchg_fault [*6] ##0 (reg_rd && reg_addr == REG_FAULT_CODE))
      |=> reg_rdata == LOG_XCHG_ERR) else $error("fault word differs from log code");

   // Highest fault wins on the display
   chk_xchg_top: assert property (xchg_fault [*6] |-> disp_code == DISP_XCHG_ERR)
      else $error("exchange fault not shown");
   chk_store_next: assert property ((store_fault && !xchg_fault) [*6]
      |-> disp_code == DISP_STORE_ERR) else $error("storage fault not shown");

   cover property (slave_down);
   cover property (reg_wr && reg_addr == REG_COMM_CTRL);
   cover property (disp_code == DISP_OFFLINE);
endmodule : fbm_status_checker

bind fbm_status fbm_status_checker i_fbm_status_checker (.mclk(mclk), .reset(reset),
   .master_found(master_found), .xchg_fault(xchg_fault), .store_fault(store_fault),
   .slave_down(slave_down), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .disp_code(disp_code));

// *** test_fbm_status.sv ***
/*
 Self-checking bench for fbm_status: status words, codes and sequences.
 Assumes slave_bus_model raises the slave events.
*/
`timescale 1ns/1ps
module test_fbm_status
   import fbm_status_pkg::*;
;
   localparam int HS = 16;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [6:0] node = 7'h00;
   logic cpu_run = 1'b1;
   logic master_found = 1'b1;
   logic [9:0] flt = 10'h000;
   logic [2:0] reg_addr = 3'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic rd_seen = 1'b0;
   logic armed = 1'b0;
   logic first_chg = 1'b0;
   logic [7:0] prev = 8'h00;
   logic [7:0] own;
   int runlen = 0;
   int mismatches = 0;
   int comparisons = 0;
   logic [15:0] rq[$];
   logic [7:0] dq[$];
   logic slave_down;
   logic slave_up;
   logic [6:0] slave_addr;
   logic [15:0] reg_rdata;
   logic [7:0] disp_code;
   logic [7:0] codes [10] = '{8'hf7, 8'hf6, 8'hf3, 8'hf4, 8'hf8, 8'hf5, 8'hf1, 8'he6, 8'hf2, 8'hfb};
   logic [15:0] logs [10] = '{16'ha407, 16'ha406, 16'ha003, 16'ha404, 16'ha408, 16'ha405,
      16'ha001, 16'ha4e6, 16'ha402, 16'ha00b};

   always #10 mclk = ~mclk;

   fbm_status #(.HOLD(HS)) i_fbm_status (.mclk(mclk), .reset(reset), .node_addr(node),
      .cpu_run(cpu_run), .master_found(master_found), .xchg_fault(flt[0]), .store_fault(flt[1]),
      .test_mode(flt[2]), .init_fail(flt[3]), .serial_fail(flt[4]), .chip_timeout(flt[5]),
      .cfg_empty(flt[6]), .remote_fault(flt[7]), .no_io_map(flt[8]), .plc_timeout(flt[9]),
      .slave_down(slave_down), .slave_up(slave_up), .slave_addr(slave_addr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .disp_code(disp_code));
   slave_bus_model i_slave_bus_model (.mclk(mclk), .slave_down(slave_down), .slave_up(slave_up),
      .slave_addr(slave_addr));

   task check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test

   // Strobes stay up between calls so reads and writes can run back to back
   task rd(input logic [2:0] a, input logic [15:0] e);
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= a;
      rq.push_back(e);
   endtask : rd

   task wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_rd <= 1'b0;
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
   endtask : wr

   task idle();
      @(posedge mclk);
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      reg_wdata <= 16'($urandom);
   endtask : idle

   // Long enough for the pin synchroniser, short of one hold period
   task settle();
      repeat (7) @(negedge mclk);
   endtask : settle

   task steady(input logic [7:0] e);
      settle();
      check(disp_code, e);
      repeat (2 * HS) @(negedge mclk);
      check(disp_code, e);
   endtask : steady

   // First item is on show now; the watcher checks the rest
   task play();
      int guard;
      guard = 0;
      check(disp_code, dq.pop_front());
      first_chg = 1'b1;
      armed = 1'b1;
      while (dq.size() > 0 && guard < 300) begin
         @(posedge mclk);
         guard++;
      end
      armed = 1'b0;
      if (dq.size() > 0) begin
         mismatches++;
         stop_test();
      end
   endtask : play

   always @(posedge mclk) rd_seen <= reg_rd;

   // Watcher: read data in the cycle after the strobe, display items on each change
   always @(negedge mclk) begin
      if (rd_seen) check(reg_rdata, rq.pop_front());
      if (disp_code !== prev) begin
         if (armed && dq.size() > 0) begin
            if (!first_chg) check(16'(runlen), 16'(HS));
            check(disp_code, dq.pop_front());
            first_chg = 1'b0;
         end
         runlen = 1;
      end else begin
         runlen++;
      end
      prev = disp_code;
   end

   initial begin
      void'($urandom(32'h862a09bc));
      node = 7'h10 + 7'($urandom % 32'h6c);
      own = {1'b0, node};
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      steady(own);
      rd(REG_NET_STATE, 16'h0004);
      rd(REG_OFFLINE_CNT, 16'h0000);
      rd(REG_FAULT_CODE, 16'h0000);
      rd(REG_COMM_HIGH, 16'h0000);
      rd(REG_COMM_CTRL, 16'h0001);
      for (int i = 5; i < 8; i++) rd(3'(i), 16'h0000);
      idle();
      // Controller stopped, no fault
      @(posedge mclk) cpu_run <= 1'b0;
      settle();
      dq = '{own, 8'h80, own, 8'h80};
      play();
      rd(REG_NET_STATE, 16'h0003);
      idle();
      // Each fault with all lower ones present
      for (int i = 0; i < 10; i++) begin
         @(posedge mclk);
         cpu_run <= (i >= 8);
         flt <= 10'h3ff << i;
         steady(codes[i]);
         rd(REG_FAULT_CODE, logs[i]);
         idle();
      end
      @(posedge mclk) flt <= 10'h000;
      node <= 7'h7e;
      steady(8'h7d);
      @(posedge mclk) node <= own[6:0];
      // Two slaves drop, one twice
      i_slave_bus_model.send(1'b1, 7'h02);
      i_slave_bus_model.send(1'b1, 7'h05);
      i_slave_bus_model.send(1'b1, 7'h05);
      settle();
      dq = '{8'he2, 8'h02, 8'he2, 8'h05, 8'he2, 8'h02};
      play();
      rd(REG_OFFLINE_CNT, 16'h0002);
      rd(REG_OFFLINE_CNT, 16'h0002);
      rd(REG_FAULT_CODE, 16'ha4e2);
      idle();
      @(posedge mclk) cpu_run <= 1'b0;
      settle();
      dq = '{8'h80, own, 8'he2, 8'h02, 8'h80, own, 8'he2, 8'h05, 8'h80};
      play();
      @(posedge mclk) cpu_run <= 1'b1;
      i_slave_bus_model.send(1'b0, 7'h02);
      settle();
      dq = '{8'he2, 8'h05, 8'he2, 8'h05};
      play();
      rd(REG_OFFLINE_CNT, 16'h0002);
      // Control word, ignored write, then the lower network states
      wr(REG_NET_STATE, 16'h0000);
      wr(REG_COMM_CTRL, 16'h0000);
      rd(REG_NET_STATE, 16'h0002);
      rd(REG_COMM_CTRL, 16'h0000);
      wr(REG_COMM_CTRL, 16'h0001);
      rd(REG_NET_STATE, 16'h0004);
      idle();
      @(posedge mclk) flt <= 10'h040;
      settle();
      rd(REG_NET_STATE, 16'h0001);
      idle();
      @(posedge mclk) master_found <= 1'b0;
      settle();
      rd(REG_NET_STATE, 16'h0000);
      idle();
      repeat (3) @(posedge mclk);
      stop_test();
   end
endmodule : test_fbm_status
